// *** host_partner.sv ***
/* Host-side model: time bases and the host flag read.
   Assumes clk_sys and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module host_partner (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Transmit end seen by host
  input wire logic tx_end,
  // Ticks and flag read
  output logic fc_tick,
  output logic rc_tick,
  output logic txe_flag_read
);
  // Carrier every cycle, RC at half rate
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fc_tick <= 1'b0;
      rc_tick <= 1'b0;
      txe_flag_read <= 1'b0;
    end else begin
      fc_tick <= 1'b1;
      rc_tick <= ~rc_tick;
      txe_flag_read <= tx_end;
    end
  end
endmodule : host_partner
`default_nettype wire

// *** nfc_protocol_timer_unit.sv ***
/*
  Protocol timer unit: no-response, field-wait, general-purpose and wake-up
  timers. Assumes all inputs synchronous to clk_sys, event inputs other than rx_busy as
  one-cycle pulses, and that fc and RC ticks arrive as one-cycle enables.
*/
`timescale 1ns/1ps
`default_nettype none
`include "timer_unit_defs.svh"

// What this block does
// [R1] Start no-response timer at transmit end
// [R2] Step is 64 or 4096 carrier periods
// [R3] Normal mode: expiry interrupts, reply stops silently
// [R4] EMV mode: always interrupt, ignore stop-all
// [R5] Start command restarts no-response timer
// [R6] Stop commands end timer without interrupt
// [R7] Active modes start at own field off
// [R8] Peer-start option starts at peer field on
// [R9] Passive target never auto-starts no-response timer
// [R10] Field-wait timer starts after transmit, NFC only
// [R11] Peer field on stops field-wait silently
// [R12] Host reads transmit-end flag first
// [R13] General timer triggered per configuration
// [R14] General timer always interrupts on expiry
// [R15] Start command restarts general timer
// [R16] Wake-up start accepted outside wake-up mode
// [R17] Wake-up expiry sets wake-up flag
// [R18] Only wake-up timer runs in power-down
// [R19] Wake-up timer bounds passive target enable
// [R20] Host reconfigures only stopped timers
// [R21] Stop-all halts every timer, EMV excepted
// [R22] Timeout is sixteen bits, two bytes
module nfc_protocol_timer_unit
  import timer_unit_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Time bases: carrier period tick and RC oscillator tick
  input wire logic fc_tick,
  input wire logic rc_tick,
  // Mode and option bits
  input wire op_mode_t op_mode,
  input wire logic nrt_step_long,
  input wire logic nrt_emv,
  input wire logic nrt_peer_start,
  input wire logic [1:0] gpt_trigger,
  // Timeout configuration
  input wire logic [7:0] nrt_timeout_hi,
  input wire logic [7:0] nrt_timeout_lo,
  input wire logic [7:0] field_wait_timeout,
  input wire logic [15:0] gpt_timeout,
  input wire logic [15:0] wakeup_timeout,
  // Commands and events
  input wire cmd_t cmd,
  input wire event_t evt,
  input wire logic irq_clear,
  // Status outputs
  output logic rx_on,
  output logic nrt_running,
  output logic nrt_timeout_flag,
  output logic field_wait_timeout_flag,
  output logic gpt_timeout_flag,
  output logic wakeup_timer_flag,
  output logic temp_enable
);

  // Registered state and its next value
  state_t st;
  state_t next_st;

  // Decoded mode groups
  logic nfc_mode;
  logic active_mode;
  logic xtal_on;
  logic fc_en;
  logic nrt_auto;
  logic gp_trig;
  logic [12:0] step_len;

  // Load value of a timer; a zero timeout still lasts one count
  function automatic logic [15:0] load16(input logic [15:0] val);
    load16 = (val == 16'h0000) ? 16'h0001 : val;
  endfunction : load16

  always_comb begin
    nfc_mode = (op_mode == mode_active_init) || (op_mode == mode_active_target) ||
               (op_mode == mode_bitrate_detect) || (op_mode == mode_passive_target);
    active_mode = (op_mode == mode_active_init) || (op_mode == mode_active_target);
    // [R18] Crystal timers stop
    xtal_on = (op_mode != mode_power_down);
    fc_en = fc_tick && xtal_on;
    // [R2] Step selection
    step_len = nrt_step_long ? `NRT_STEP_LONG : `NRT_STEP_SHORT;
    // [R1] Reader transmit end
    nrt_auto = (op_mode == mode_reader) && evt.tx_end;
    // [R7] Own field off
    if (!nrt_peer_start && (active_mode || op_mode == mode_bitrate_detect) && evt.tx_field_off) begin
      nrt_auto = 1'b1;
    end
    // [R8] Peer field on
    if (nrt_peer_start && active_mode && evt.peer_field_on) begin
      nrt_auto = 1'b1;
    end
    // [R9] Passive target excluded
    if (op_mode == mode_passive_target) begin
      nrt_auto = 1'b0;
    end
    // [R13] Trigger selection
    unique case (gpt_trigger)
      `GPT_TRIG_RX_START: gp_trig = evt.rx_start;
      `GPT_TRIG_RX_END: gp_trig = evt.rx_end;
      `GPT_TRIG_FIELD_OFF: gp_trig = active_mode && evt.tx_field_off;
      default: gp_trig = 1'b0;
    endcase
  end

  // Next-state logic of all four timers
  always_comb begin
    next_st = st;
    // Host acknowledges all flags; a new event in the same cycle wins
    if (irq_clear) begin
      next_st.irq_nrt = 1'b0;
      next_st.irq_fw = 1'b0;
      next_st.irq_gp = 1'b0;
      next_st.irq_wu = 1'b0;
    end
    // [R12] Transmit-end flag read
    if (evt.txe_flag_read) begin
      next_st.txe_seen = 1'b1;
    end
    // No-response timer counting
    if (st.nrt_run == tmr_run && fc_en) begin
      if (st.nrt_pre >= step_len - 13'h0001) begin
        next_st.nrt_pre = `COUNT13_RESET;
        // [R22] Count down per step
        if (st.nrt_count <= 16'h0001) begin
          next_st.nrt_run = tmr_idle;
          next_st.nrt_count = `COUNT16_RESET;
          // [R3] [R4] Expiry interrupt
          next_st.irq_nrt = 1'b1;
          // [R4] Reply in progress keeps receiver
          if (!(nrt_emv && evt.rx_busy)) begin
            next_st.rx_on = 1'b0;
          end
        end else begin
          next_st.nrt_count = st.nrt_count - 16'h0001;
        end
      end else begin
        next_st.nrt_pre = st.nrt_pre + 13'h0001;
      end
    end
    // [R3] Reply start stops silently
    if (!nrt_emv && evt.rx_start && st.nrt_run == tmr_run) begin
      next_st.nrt_run = tmr_idle;
      // Idle prescaler must rest at zero, the field-wait timer keys on it
      next_st.nrt_pre = `COUNT13_RESET;
    end
    // [R6] [R21] Stop commands, EMV exception
    if (cmd.stop_nrt || (cmd.stop_all && !nrt_emv)) begin
      next_st.nrt_run = tmr_idle;
      // Cleared so a stopped timer never stalls the field-wait count
      next_st.nrt_pre = `COUNT13_RESET;
    end
    // [R5] Start or restart
    if ((cmd.start_nrt || nrt_auto) && xtal_on) begin
      next_st.nrt_run = tmr_run;
      next_st.nrt_pre = `COUNT13_RESET;
      next_st.nrt_count = load16({nrt_timeout_hi, nrt_timeout_lo});
      next_st.rx_on = 1'b1;
    end
    // Field-wait timer counting, one count per carrier tick with the no-response prescaler at zero
    if (st.fw_run == tmr_run && fc_en && st.nrt_pre == `COUNT13_RESET) begin
      if (st.fw_count <= 8'h01) begin
        next_st.fw_run = tmr_idle;
        // [R10] Timeout interrupt
        next_st.irq_fw = 1'b1;
      end else begin
        next_st.fw_count = st.fw_count - 8'h01;
      end
    end
    // [R11] Peer field stops it
    if (evt.peer_field_on || cmd.stop_all) begin
      next_st.fw_run = tmr_idle;
    end
    // [R10] Start after transmit, NFC only
    if (nfc_mode && evt.tx_field_off && st.txe_seen && xtal_on) begin
      next_st.fw_run = tmr_run;
      next_st.fw_count = (field_wait_timeout == 8'h00) ? 8'h01 : field_wait_timeout;
      next_st.txe_seen = 1'b0;
    end
    // General-purpose timer counting per carrier tick
    if (st.gp_run == tmr_run && fc_en) begin
      if (st.gp_count <= 16'h0001) begin
        next_st.gp_run = tmr_idle;
        // [R14] Always interrupts
        next_st.irq_gp = 1'b1;
      end else begin
        next_st.gp_count = st.gp_count - 16'h0001;
      end
    end
    // [R21] Halt on stop-all
    if (cmd.stop_all) begin
      next_st.gp_run = tmr_idle;
    end
    // [R15] [R13] Start or restart
    if ((cmd.start_gpt || gp_trig) && xtal_on) begin
      next_st.gp_run = tmr_run;
      next_st.gp_count = load16(gpt_timeout);
    end
    // Wake-up timer counting on RC ticks, also in power-down
    if (st.wu_run == tmr_run && rc_tick) begin
      if (st.wu_count <= 16'h0001) begin
        next_st.wu_run = tmr_idle;
        // [R17] Wake-up flag
        next_st.irq_wu = 1'b1;
        // [R19] Enable window ends
        next_st.temp_enable = 1'b0;
      end else begin
        next_st.wu_count = st.wu_count - 16'h0001;
      end
    end
    // [R21] Halt on stop-all
    if (cmd.stop_all) begin
      next_st.wu_run = tmr_idle;
      next_st.temp_enable = 1'b0;
    end
    // [R16] Accepted except wake-up mode
    if (cmd.start_wut && op_mode != mode_wakeup) begin
      next_st.wu_run = tmr_run;
      next_st.wu_count = load16(wakeup_timeout);
    end
    // [R19] Peer field opens enable window
    if (op_mode == mode_passive_target && evt.peer_field_on && st.wu_run == tmr_idle) begin
      next_st.wu_run = tmr_run;
      next_st.wu_count = load16(wakeup_timeout);
      next_st.temp_enable = 1'b1;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from state flip-flops
  assign rx_on = st.rx_on;
  assign nrt_running = (st.nrt_run == tmr_run);
  assign nrt_timeout_flag = st.irq_nrt;
  assign field_wait_timeout_flag = st.irq_fw;
  assign gpt_timeout_flag = st.irq_gp;
  assign wakeup_timer_flag = st.irq_wu;
  assign temp_enable = st.temp_enable;

endmodule : nfc_protocol_timer_unit
`default_nettype wire

// *** nfc_protocol_timer_unit_bench.sv ***
/* Self-checking bench for the timer unit.
   Assumes host_partner and the checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module nfc_protocol_timer_unit_bench;
  import timer_unit_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  op_mode_t op_mode = mode_reader;
  logic nrt_step_long = 1'b0;
  logic nrt_emv = 1'b0;
  logic nrt_peer_start = 1'b0;
  logic [1:0] gpt_trigger = 2'h0;
  logic [7:0] nrt_timeout_hi = 8'h00;
  logic [7:0] nrt_timeout_lo = 8'h01;
  logic [7:0] field_wait_timeout = 8'h01;
  logic [15:0] gpt_timeout = 16'h0010;
  logic [15:0] wakeup_timeout = 16'h0004;
  cmd_t cmd = '0;
  event_t ev = '0;
  event_t evt_w;
  logic irq_clear = 1'b0;
  logic fc_tick, rc_tick, txe_rd, rx_on, nrt_running, nrt_timeout_flag;
  logic field_wait_timeout_flag, gpt_timeout_flag, wakeup_timer_flag, temp_enable;
  int error_cnt = 0;
  int tests_run = 0;
  always #5 clk_sys = ~clk_sys;
  // Host read pulse merged into events
  always_comb begin
    evt_w = ev;
    evt_w.txe_flag_read = txe_rd;
  end
  host_partner u_host (.clk_sys, .rst_n, .tx_end(ev.tx_end), .fc_tick, .rc_tick, .txe_flag_read(txe_rd));
  nfc_protocol_timer_unit u_dut (.clk_sys, .rst_n, .fc_tick, .rc_tick, .op_mode, .nrt_step_long, .nrt_emv,
    .nrt_peer_start, .gpt_trigger, .nrt_timeout_hi, .nrt_timeout_lo, .field_wait_timeout, .gpt_timeout,
    .wakeup_timeout, .cmd, .evt(evt_w), .irq_clear, .rx_on, .nrt_running, .nrt_timeout_flag,
    .field_wait_timeout_flag, .gpt_timeout_flag, .wakeup_timer_flag, .temp_enable);
  task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  // One-cycle command pulse, edge between calls
  task pc(input cmd_t c);
    @(posedge clk_sys);
    cmd <= c;
    @(posedge clk_sys);
    cmd <= '0;
    #1;
  endtask : pc
  task pe(input event_t e);
    @(posedge clk_sys);
    ev <= e;
    @(posedge clk_sys);
    ev <= '0;
    #1;
  endtask : pe
  task clr;
    @(posedge clk_sys);
    irq_clear <= 1'b1;
    @(posedge clk_sys);
    irq_clear <= 1'b0;
    #1;
  endtask : clr
  // Short and long step expiry
  task t_expire;
    for (int i = 0; i < 2; i++) begin
      nrt_step_long <= i[0];
      pc(5'h10);
      chk("nrt_running", nrt_running, 1);
      cyc(i ? 4000 : 60);
      chk("nrt early", nrt_timeout_flag, 0);
      cyc(i ? 150 : 10);
      chk("nrt flag", nrt_timeout_flag, 1);
      chk("rx_on", rx_on, 0);
      clr;
      chk("nrt cleared", nrt_timeout_flag, 0);
    end
    nrt_step_long <= 1'b0;
  endtask : t_expire
  // Auto start, then reply stops it
  task t_reply;
    pe(7'h40);
    chk("auto start", nrt_running, 1);
    pe(7'h08);
    chk("reply stop", nrt_running, 0);
    cyc(80);
    chk("no flag", nrt_timeout_flag, 0);
  endtask : t_reply
  // Emv mode, then stop commands
  task t_emv;
    nrt_emv <= 1'b1;
    pc(5'h10);
    pc(5'h01);
    chk("emv run", nrt_running, 1);
    ev.rx_busy <= 1'b1;
    cyc(80);
    chk("emv flag", nrt_timeout_flag, 1);
    chk("emv rx_on", rx_on, 1);
    ev.rx_busy <= 1'b0;
    nrt_emv <= 1'b0;
    clr;
    pc(5'h10);
    pc(5'h08);
    chk("stop", nrt_running, 0);
    pc(5'h10);
    pc(5'h01);
    chk("stop all", nrt_running, 0);
    cyc(80);
    chk("silent", nrt_timeout_flag, 0);
  endtask : t_emv
  // Auto start per mode and option
  task t_modes;
    op_mode_t md[4] = '{mode_active_init, mode_active_target, mode_bitrate_detect, mode_passive_target};
    logic [3:0] ps = 4'h6;
    event_t ee[4] = '{7'h20, 7'h10, 7'h10, 7'h40};
    logic [3:0] ex = 4'h3;
    for (int i = 0; i < 4; i++) begin
      op_mode <= md[i];
      nrt_peer_start <= ps[i];
      pe(ee[i]);
      chk("mode start", nrt_running, ex[i]);
      pc(5'h08);
    end
    op_mode <= mode_power_down;
    pc(5'h10);
    chk("power down", nrt_running, 0);
    op_mode <= mode_reader;
    clr;
  endtask : t_modes
  // General timer restart and triggers
  task t_gpt;
    event_t te[3] = '{7'h08, 7'h04, 7'h20};
    pc(5'h04);
    cyc(10);
    pc(5'h04);
    cyc(12);
    chk("gpt restart", gpt_timeout_flag, 0);
    cyc(10);
    chk("gpt flag", gpt_timeout_flag, 1);
    op_mode <= mode_active_init;
    for (int j = 0; j < 3; j++) begin
      gpt_trigger <= 2'(j + 1);
      clr;
      pe(te[j]);
      cyc(30);
      chk("gpt trigger", gpt_timeout_flag, 1);
      pc(5'h08);
    end
    gpt_trigger <= 2'h0;
    op_mode <= mode_reader;
  endtask : t_gpt
  // Wake-up start refused in wake-up mode
  task t_wut;
    op_mode <= mode_wakeup;
    pc(5'h02);
    cyc(40);
    chk("wut refused", wakeup_timer_flag, 0);
    op_mode <= mode_reader;
    pc(5'h02);
    cyc(20);
    chk("wut flag", wakeup_timer_flag, 1);
  endtask : t_wut
  // Field-wait timer, enable window, power-down
  task t_fwait;
    op_mode <= mode_active_init;
    nrt_peer_start <= 1'b1;
    field_wait_timeout <= 8'h20;
    clr;
    pe(7'h20);
    cyc(40);
    chk("fw no read", field_wait_timeout_flag, 0);
    pe(7'h40);
    pe(7'h20);
    cyc(28);
    chk("fw early", field_wait_timeout_flag, 0);
    cyc(8);
    chk("fw flag", field_wait_timeout_flag, 1);
    clr;
    pe(7'h40);
    pe(7'h20);
    cyc(10);
    pe(7'h10);
    pc(5'h08);
    cyc(40);
    chk("fw peer stop", field_wait_timeout_flag, 0);
    op_mode <= mode_passive_target;
    nrt_peer_start <= 1'b0;
    pe(7'h10);
    chk("enable open", temp_enable, 1);
    cyc(20);
    chk("enable closed", temp_enable, 0);
    op_mode <= mode_power_down;
    clr;
    pc(5'h04);
    pc(5'h02);
    cyc(30);
    chk("pd gpt", gpt_timeout_flag, 0);
    chk("pd wut", wakeup_timer_flag, 1);
    op_mode <= mode_reader;
    field_wait_timeout <= 8'h01;
  endtask : t_fwait
  // High timeout byte pairs with low byte
  task t_pair;
    nrt_timeout_hi <= 8'h01;
    nrt_timeout_lo <= 8'h00;
    clr;
    pc(5'h10);
    cyc(16300);
    chk("nrt pair early", nrt_timeout_flag, 0);
    cyc(150);
    chk("nrt pair flag", nrt_timeout_flag, 1);
    nrt_timeout_hi <= 8'h00;
    nrt_timeout_lo <= 8'h01;
  endtask : t_pair
  task end_sim;
    $display("Checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_expire;
    t_reply;
    t_emv;
    t_modes;
    t_gpt;
    t_wut;
    t_fwait;
    t_pair;
    end_sim;
  end
  // Watchdog well past the expected run
  initial begin
    #400000;
    error_cnt++;
    end_sim;
  end
endmodule : nfc_protocol_timer_unit_bench
bind nfc_protocol_timer_unit timer_unit_assertions u_chk (.clk_sys, .rst_n, .fc_tick, .rc_tick, .op_mode,
  .nrt_emv, .cmd, .evt, .rx_on, .nrt_running, .nrt_timeout_flag, .wakeup_timer_flag);
`default_nettype wire

// *** timer_unit_assertions.sv ***
/* Port checker for the protocol timer unit.
   Assumes a bind to the timer unit module; one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module timer_unit_assertions
  import timer_unit_pkg::*;
(
  // Clock, reset, ticks
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic fc_tick,
  input wire logic rc_tick,
  // Controls
  input wire op_mode_t op_mode,
  input wire logic nrt_emv,
  input wire cmd_t cmd,
  input wire event_t evt,
  // Status
  input wire logic rx_on,
  input wire logic nrt_running,
  input wire logic nrt_timeout_flag,
  input wire logic wakeup_timer_flag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Expiry: flag rises as the timer drops
  sequence s_expire;
    $rose(nrt_timeout_flag) ##0 !nrt_running;
  endsequence
  // No field event that could restart the timer
  sequence s_quiet;
    !evt.tx_field_off && !evt.peer_field_on;
  endsequence
  AST_TX_END_START: assert property ((evt.tx_end && op_mode == mode_reader && cmd == 5'h00 ##0 s_quiet) |=> nrt_running)
    else $error("no start at transmit end");
  AST_STEP_TICK: assert property ($rose(nrt_timeout_flag) |-> $past(fc_tick))
    else $error("expiry without carrier tick");
  AST_EXPIRE_RX_OFF: assert property ((s_expire ##0 !$past(nrt_emv)) |-> !rx_on)
    else $error("receiver left on at expiry");
  AST_REPLY_STOP: assert property ((nrt_running && evt.rx_start && !nrt_emv && cmd == 5'h00 ##0 s_quiet) |=> !nrt_running && !$rose(nrt_timeout_flag))
    else $error("reply did not stop timer silently");
  AST_EMV_KEEP: assert property ((nrt_emv && nrt_running && cmd == 5'h01) |=> nrt_running)
    else $error("stop-all halted timer in emv mode");
  AST_START_CMD: assert property ((cmd.start_nrt && op_mode != mode_power_down) |=> nrt_running && rx_on)
    else $error("start command not taken");
  AST_STOP_SILENT: assert property ((nrt_running && cmd == 5'h08 && !evt.tx_end ##0 s_quiet) |=> !nrt_running && !$rose(nrt_timeout_flag))
    else $error("stop command not silent");
  AST_PASSIVE_IDLE: assert property ((op_mode == mode_passive_target && !nrt_running && cmd == 5'h00) |=> !nrt_running)
    else $error("auto start in passive target");
  AST_WU_TICK: assert property ($rose(wakeup_timer_flag) |-> $past(rc_tick))
    else $error("wake-up flag without rc tick");
endmodule : timer_unit_assertions
`default_nettype wire

// *** timer_unit_defs.svh ***
/*
  Constants for the protocol timer unit: trigger selection codes, reset values
  and timing counts. Assumes inclusion by bare name from the package or module.
*/
`ifndef TIMER_UNIT_DEFS_SVH
`define TIMER_UNIT_DEFS_SVH
// Carrier periods per no-response count, short and long step
`define NRT_STEP_SHORT 13'h0040
`define NRT_STEP_LONG 13'h1000
// Reset values of timer counts
`define COUNT16_RESET 16'h0000
`define COUNT8_RESET 8'h00
`define COUNT13_RESET 13'h0000
// General-purpose trigger selections
`define GPT_TRIG_NONE 2'h0
`define GPT_TRIG_RX_START 2'h1
`define GPT_TRIG_RX_END 2'h2
`define GPT_TRIG_FIELD_OFF 2'h3
`endif

// *** timer_unit_pkg.sv ***
/*
  Types for the protocol timer unit: operating modes, command strobes and
  state record. Assumes the defs header sits in the same folder.
*/
`include "timer_unit_defs.svh"
package timer_unit_pkg;
  // Operating mode of the surrounding device
  typedef enum logic [2:0] {
    mode_reader = 3'h0,
    mode_active_init = 3'h1,
    mode_active_target = 3'h2,
    mode_bitrate_detect = 3'h3,
    mode_passive_target = 3'h4,
    mode_wakeup = 3'h5,
    mode_power_down = 3'h6
  } op_mode_t;

  // One-cycle direct command strobes from the host
  typedef struct packed {
    logic start_nrt;
    logic stop_nrt;
    logic start_gpt;
    logic start_wut;
    logic stop_all;
  } cmd_t;

  // Link and field events, one-cycle pulses except the rx_busy level
  typedef struct packed {
    logic tx_end;
    logic tx_field_off;
    logic peer_field_on;
    logic rx_start;
    logic rx_end;
    logic rx_busy;
    logic txe_flag_read;
  } event_t;

  // Timer run state
  typedef enum logic [1:0] {
    tmr_idle = 2'b00,
    tmr_run = 2'b01
  } run_t;

  // Complete state of the timer unit
  typedef struct packed {
    run_t nrt_run;
    logic [15:0] nrt_count;
    logic [12:0] nrt_pre;
    run_t fw_run;
    logic [7:0] fw_count;
    run_t gp_run;
    logic [15:0] gp_count;
    run_t wu_run;
    logic [15:0] wu_count;
    logic txe_seen;
    logic rx_on;
    logic irq_nrt;
    logic irq_fw;
    logic irq_gp;
    logic irq_wu;
    logic temp_enable;
  } state_t;
endpackage : timer_unit_pkg
